// *** shared/wed_pkg.sv ***
/*
  constants, register map and types of the wake event detector.
  assumes a 32-bit classic wishbone register bus with byte addresses.
*/
// What this block does
// - link change mode flags any link change
// - link flag drives wake pin, event status
// - link change asserts event if enable/override
// - compare frames against up to eight patterns
// - pattern match sets flag and event status
// - 64x40 pattern ram, indirect access only
// - match mode locks ram and data registers
// - index read in match mode: bit valid
// - clearing match mode latches word address
// - ram written on high data write
// - word 0 byte 0 enables patterns
// - word 0/1 bytes 1-4 point to patterns
// - control byte top bit ends pattern
// - control bits 6-4 skip frame dwords
// - control bits 3-0 mask pattern bytes
// - ram kept across all resets
// - wake mode in suspend, with power loss or wake enable, blocks master and transmit, flushes
// - wake frame: sixteen address copies after length
// - any mismatch voids the wake sequence
// - address modes widen wake destination check
package wed_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_INDEX    = 8'h00;
    localparam logic [7:0] OFS_LOWDATA  = 8'h04;
    localparam logic [7:0] OFS_HIGHDATA = 8'h08;
    localparam logic [7:0] OFS_WAKECTL  = 8'h0c;
    localparam logic [7:0] OFS_EXTCTL   = 8'h10;
    localparam logic [7:0] OFS_PMCTL    = 8'h14;
    localparam logic [7:0] OFS_STALO    = 8'h18;
    localparam logic [7:0] OFS_STAHI    = 8'h1c;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_MATCHMODE = 7;
    localparam int BIT_WAKEHIT   = 5;
    localparam int BIT_ADDRB     = 6;
    localparam int BIT_PATMAT    = 7;
    localparam int BIT_LINK_CHANGE_MODE    = 8;
    localparam int BIT_LINK_CHANGE_DETECTED     = 9;
    localparam int BIT_OVR       = 10;
    localparam int BIT_SUSPEND   = 0;
    localparam int BIT_WAKEMODE  = 1;
    localparam int BIT_WAKEEN    = 2;
    localparam int BIT_ADDRA     = 5;
    localparam int BIT_PMEEN     = 8;
    localparam int BIT_PMESTAT   = 15;
    localparam int BIT_LAST      = 7;

    // ----------------------------------------
    // sizes, counts and reset values
    // ----------------------------------------
    localparam int RAM_DEPTH = 64;
    localparam int RAM_W     = 40;
    localparam logic [10:0] IDX_DATA  = 11'd14;
    localparam logic [10:0] IDX_DEST  = 11'd6;
    localparam logic [2:0]  ADDR_LAST = 3'h5;
    localparam logic [3:0]  COPY_LAST = 4'hf;
    localparam logic [47:0] STA_RESET = 48'h0;
    localparam logic [6:0]  ADDR_RESET = 7'h00;

    // ----------------------------------------
    // receive byte stream
    // ----------------------------------------
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } wed_rx_t;

endpackage : wed_pkg

// *** verilog/wed_wake_event_detect.sv ***
/*
  wake event detector: link change, pattern match and wake frame.
  assumes a wishbone master, a receive byte stream without fcs.
*/
`timescale 1ns/10ps
`default_nettype none
module wed_wake_event_detect #(
    parameter int NPAT = 8
) (
    input  wire logic           clock,
    input  wire logic           resetn,
    input  wire logic [7:0]     adr_i,
    input  wire logic [31:0]    dat_i,
    input  wire logic           we_i,
    input  wire logic [3:0]     sel_i,
    input  wire logic           stb_i,
    input  wire logic           cyc_i,
    output logic                ack_o,
    output logic [31:0]         dat_o,
    input  wire wed_pkg::wed_rx_t rxByte,
    input  wire logic           linkStatus,
    input  wire logic           powerGoodIn,
    input  wire logic           cfgLoad,
    input  wire logic           cfgLinkChangeMode,
    output logic                remoteWakeOut,
    output logic                eventOut,
    output logic                busMasterBlock,
    output logic                txBlock,
    output logic                rxFlush
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic              ack_q;
    logic [31:0]       dat_q;
    logic              matchMode_q;
    logic [6:0]        ramAddr_q;
    logic [7:0]        idxByte_q;
    logic [15:0]       lowData_q;
    logic              link_change_mode_q;
    logic              ovr_q;
    logic              addrA_q;
    logic              addrB_q;
    logic              susp_q;
    logic              wakeMode_q;
    logic              wakeEn_q;
    logic              pmeEn_q;
    logic              linkDet_q;
    logic              patMat_q;
    logic              wakeHit_q;
    logic              pmeStat_q;
    logic [47:0]       sta_q;
    logic [39:0]       ram [wed_pkg::RAM_DEPTH];
    logic              lnk1_q;
    logic              lnk2_q;
    logic              lnkPrev_q;
    logic              rwu_q;
    logic              evt_q;
    logic              block_q;
    logic [10:0]       byteCnt_q;
    logic [31:0]       buf_q;
    logic [2:0]        seq_q;
    logic [3:0]        cop_q;
    logic              destOk_q;
    logic [5:0]        ptr_q [NPAT];
    logic [2:0]        skc_q [NPAT];
    logic [NPAT-1:0]   alive_q;
    logic [NPAT-1:0]   cmpOk;
    logic [NPAT-1:0]   hitVec;
    logic [31:0]       rdData;

    function automatic logic [7:0] staByte(input logic [47:0] a, input logic [2:0] i);
        return a[{i, 3'b000} +: 8];
    endfunction : staByte
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
        end
    endfunction : merge

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        acc   = cyc_i & stb_i & ~ack_q;
    wire        wr    = acc & we_i;
    wire        wrIdx = wr & (adr_i == wed_pkg::OFS_INDEX) & sel_i[0];
    wire        wrLo  = wr & (adr_i == wed_pkg::OFS_LOWDATA) & ~matchMode_q;
    wire        wrHi  = wr & (adr_i == wed_pkg::OFS_HIGHDATA) & ~matchMode_q;
    wire        wrWc  = wr & (adr_i == wed_pkg::OFS_WAKECTL);
    wire        wrEc  = wr & (adr_i == wed_pkg::OFS_EXTCTL);
    wire        wrPm  = wr & (adr_i == wed_pkg::OFS_PMCTL);
    wire [39:0] cur   = ram[ramAddr_q[5:0]];
    wire [31:0] wcOld = {21'h0, ovr_q, 1'b0, link_change_mode_q, 1'b0, addrB_q, 6'h0};
    wire [31:0] ecOld = {26'h0, addrA_q, 2'h0, wakeEn_q, wakeMode_q, susp_q};
    wire [31:0] wcNew = merge(wcOld, dat_i, sel_i);
    wire [31:0] ecNew = merge(ecOld, dat_i, sel_i);
    wire [31:0] loMrg = merge({16'h0, lowData_q}, dat_i, sel_i);
    wire [31:0] hiMrg = merge({16'h0, cur[39:24]}, dat_i, sel_i);
    wire [31:0] shMrg = merge({16'h0, sta_q[47:32]}, dat_i, sel_i);
    wire [31:0] wcW   = merge(32'h0, dat_i, sel_i);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            dat_q <= acc ? rdData : 32'h0;
        end
    end

    always_comb begin
        unique case (adr_i)
            wed_pkg::OFS_INDEX:
                rdData = matchMode_q ? 32'h0000_0080 :
                         {16'h0, cur[7:0], 1'b0, ramAddr_q};
            wed_pkg::OFS_LOWDATA:  rdData = {16'h0, cur[23:8]};
            wed_pkg::OFS_HIGHDATA: rdData = {16'h0, cur[39:24]};
            wed_pkg::OFS_WAKECTL:
                rdData = wcOld | {22'h0, linkDet_q, 1'b0, patMat_q, 1'b0, wakeHit_q, 5'h0};
            wed_pkg::OFS_EXTCTL:   rdData = ecOld;
            wed_pkg::OFS_PMCTL:    rdData = {16'h0, pmeStat_q, 6'h0, pmeEn_q, 8'h0};
            wed_pkg::OFS_STALO:    rdData = sta_q[31:0];
            wed_pkg::OFS_STAHI:    rdData = {16'h0, sta_q[47:32]};
            default:               rdData = 32'h0;
        endcase
    end

    // ----------------------------------------
    // indirect pattern ram access
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            matchMode_q <= 1'b0;
            ramAddr_q   <= wed_pkg::ADDR_RESET;
            idxByte_q   <= 8'h00;
            lowData_q   <= 16'h0000;
        end else begin
            if (wrIdx && dat_i[wed_pkg::BIT_MATCHMODE]) begin
                matchMode_q <= 1'b1;
            end else if (wrIdx) begin
                matchMode_q <= 1'b0;
                ramAddr_q   <= dat_i[6:0];
                if (sel_i[1]) begin
                    idxByte_q <= dat_i[15:8];
                end
            end
            if (wrLo) begin
                lowData_q <= loMrg[15:0];
            end
        end
    end

    // no reset: contents survive every reset
    always_ff @(posedge clock) begin
        if (wrHi) begin
            ram[ramAddr_q[5:0]] <= {hiMrg[15:0], lowData_q, idxByte_q};
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link_change_mode_q   <= 1'b0;
            ovr_q      <= 1'b0;
            addrB_q    <= 1'b0;
            addrA_q    <= 1'b0;
            susp_q     <= 1'b0;
            wakeMode_q <= 1'b0;
            wakeEn_q   <= 1'b0;
            pmeEn_q    <= 1'b0;
            sta_q      <= wed_pkg::STA_RESET;
        end else begin
            if (cfgLoad) begin
                link_change_mode_q <= cfgLinkChangeMode;
            end else if (wrWc) begin
                link_change_mode_q <= wcNew[wed_pkg::BIT_LINK_CHANGE_MODE];
            end
            if (wrWc) begin
                ovr_q   <= wcNew[wed_pkg::BIT_OVR];
                addrB_q <= wcNew[wed_pkg::BIT_ADDRB];
            end
            if (wrEc) begin
                susp_q     <= ecNew[wed_pkg::BIT_SUSPEND];
                wakeMode_q <= ecNew[wed_pkg::BIT_WAKEMODE];
                wakeEn_q   <= ecNew[wed_pkg::BIT_WAKEEN];
                addrA_q    <= ecNew[wed_pkg::BIT_ADDRA];
            end
            if (wrPm && sel_i[1]) begin
                pmeEn_q <= dat_i[wed_pkg::BIT_PMEEN];
            end
            if (wr && adr_i == wed_pkg::OFS_STALO) begin
                sta_q[31:0] <= merge(sta_q[31:0], dat_i, sel_i);
            end
            if (wr && adr_i == wed_pkg::OFS_STAHI) begin
                sta_q[47:32] <= shMrg[15:0];
            end
        end
    end

    // ----------------------------------------
    // link change
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lnk1_q    <= 1'b0;
            lnk2_q    <= 1'b0;
            lnkPrev_q <= 1'b0;
        end else begin
            lnk1_q    <= linkStatus;
            lnk2_q    <= lnk1_q;
            lnkPrev_q <= lnk2_q;
        end
    end
    wire lcSet = link_change_mode_q & (lnk2_q ^ lnkPrev_q);

    // ----------------------------------------
    // receive byte position
    // ----------------------------------------
    wire [10:0] curIdx = rxByte.sof ? 11'd0 : byteCnt_q;
    wire [7:0]  b      = rxByte.data;
    wire        dwDone = rxByte.valid & (curIdx[1:0] == 2'd3);
    wire [31:0] word   = {b, buf_q[23:0]};
    wire        wakeActive = wakeMode_q & susp_q & (~powerGoodIn | wakeEn_q);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            byteCnt_q <= 11'd0;
            buf_q     <= 32'h0;
        end else if (rxByte.valid) begin
            byteCnt_q <= (&curIdx) ? curIdx : 11'(curIdx + 11'd1);
            buf_q[{curIdx[1:0], 3'b000} +: 8] <= b;
        end
    end

    // ----------------------------------------
    // wake frame scan
    // ----------------------------------------
    wire seqEq  = b == staByte(sta_q, seq_q);
    wire inData = rxByte.valid & ~rxByte.sof & (curIdx >= wed_pkg::IDX_DATA);
    wire magic  = inData & seqEq & (seq_q == wed_pkg::ADDR_LAST)
                  & (cop_q == wed_pkg::COPY_LAST)
                  & (destOk_q | addrA_q | addrB_q) & wakeActive;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            seq_q    <= 3'h0;
            cop_q    <= 4'h0;
            destOk_q <= 1'b0;
        end else if (rxByte.valid && rxByte.sof) begin
            seq_q    <= 3'h0;
            cop_q    <= 4'h0;
            destOk_q <= b == staByte(sta_q, 3'h0);
        end else if (rxByte.valid) begin
            if (curIdx < wed_pkg::IDX_DEST) begin
                destOk_q <= destOk_q & (b == staByte(sta_q, curIdx[2:0]));
            end
            if (inData && seqEq) begin
                seq_q <= (seq_q == wed_pkg::ADDR_LAST) ? 3'h0 : 3'(seq_q + 3'h1);
                if (seq_q == wed_pkg::ADDR_LAST) begin
                    cop_q <= 4'(cop_q + 4'h1);
                end
            end else if (inData) begin
                cop_q <= 4'h0;
                seq_q <= (b == staByte(sta_q, 3'h0)) ? 3'h1 : 3'h0;
            end
        end
    end

    // ----------------------------------------
    // pattern trackers
    // ----------------------------------------
    always_comb begin
        logic [39:0] w;
        w = 40'h0;
        for (int k = 0; k < NPAT; k++) begin
            w = ram[ptr_q[k]];
            cmpOk[k] = 1'b1;
            for (int j = 0; j < 4; j++) begin
                if (w[j] && w[8+8*j +: 8] != word[8*j +: 8]) begin
                    cmpOk[k] = 1'b0;
                end
            end
            hitVec[k] = alive_q[k] & dwDone & (skc_q[k] == w[6:4]) & cmpOk[k]
                        & w[wed_pkg::BIT_LAST];
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            alive_q <= '0;
            for (int k = 0; k < NPAT; k++) begin
                ptr_q[k] <= 6'h0;
                skc_q[k] <= 3'h0;
            end
        end else if (!matchMode_q) begin
            alive_q <= '0;
        end else if (rxByte.valid && rxByte.sof) begin
            for (int k = 0; k < NPAT; k++) begin
                alive_q[k] <= ram[0][k];
                ptr_q[k]   <= ram[k/4][8+8*(k%4) +: 6];
                skc_q[k]   <= 3'h0;
            end
        end else if (dwDone) begin
            for (int k = 0; k < NPAT; k++) begin
                if (alive_q[k] && skc_q[k] != ram[ptr_q[k]][6:4]) begin
                    skc_q[k] <= 3'(skc_q[k] + 3'h1);
                end else if (alive_q[k] && (!cmpOk[k] || ram[ptr_q[k]][wed_pkg::BIT_LAST])) begin
                    alive_q[k] <= 1'b0;
                end else if (alive_q[k]) begin
                    ptr_q[k] <= 6'(ptr_q[k] + 6'h1);
                    skc_q[k] <= 3'h0;
                end
            end
        end
    end

    // ----------------------------------------
    // sticky flags and event status
    // ----------------------------------------
    wire patSet = |hitVec;
    wire anySet = lcSet | patSet | magic;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            linkDet_q <= 1'b0;
            patMat_q  <= 1'b0;
            wakeHit_q <= 1'b0;
            pmeStat_q <= 1'b0;
        end else begin
            linkDet_q <= lcSet | (linkDet_q & ~(wrWc & wcW[wed_pkg::BIT_LINK_CHANGE_DETECTED]));
            patMat_q  <= patSet | (patMat_q & ~(wrWc & wcW[wed_pkg::BIT_PATMAT]));
            wakeHit_q <= magic | (wakeHit_q & ~(wrWc & wcW[wed_pkg::BIT_WAKEHIT]));
            pmeStat_q <= anySet | (pmeStat_q & ~(wrPm & wcW[wed_pkg::BIT_PMESTAT]));
        end
    end

    // ----------------------------------------
    // output pins
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rwu_q   <= 1'b0;
            evt_q   <= 1'b0;
            block_q <= 1'b0;
        end else begin
            rwu_q   <= linkDet_q | wakeHit_q;
            evt_q   <= pmeStat_q & (pmeEn_q | (ovr_q & (linkDet_q | wakeHit_q)));
            block_q <= wakeActive;
        end
    end

    assign ack_o          = ack_q;
    assign dat_o          = dat_q;
    assign remoteWakeOut  = rwu_q;
    assign eventOut       = evt_q;
    assign busMasterBlock = block_q;
    assign txBlock        = block_q;
    assign rxFlush        = block_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence sWrHigh;
        wrHi;
    endsequence
    sequence sWrIdxClear;
        wrIdx && !dat_i[wed_pkg::BIT_MATCHMODE];
    endsequence
    chk_link_flag: assert property (lcSet |=> linkDet_q && pmeStat_q)
        else $error("link change not flagged");
    chk_wake_pin: assert property ($rose(linkDet_q) |=> remoteWakeOut)
        else $error("wake pin not asserted");
    chk_event_ovr: assert property (pmeStat_q && linkDet_q && ovr_q |=> eventOut)
        else $error("override did not assert event");
    chk_event_pin: assert property (pmeStat_q && pmeEn_q |=> eventOut)
        else $error("event pin missing");
    chk_ram_lock: assert property (matchMode_q && !wrIdx |=> $stable({lowData_q, ramAddr_q}))
        else $error("data register changed in match mode");
    chk_index_latch: assert property (sWrIdxClear |=> !matchMode_q
                                      && ramAddr_q == $past(dat_i[6:0]))
        else $error("index address not latched");
    chk_ram_write: assert property (sWrHigh |=> ram[$past(ramAddr_q[5:0])][23:8]
                                    == $past(lowData_q))
        else $error("ram word not written");
    chk_wake_block: assert property (wakeActive |=> busMasterBlock && rxFlush)
        else $error("wake mode did not block");
    chk_flag_sticky: assert property (patMat_q && !wrWc |=> patMat_q)
        else $error("pattern flag lost");
    chk_bus_ack: assert property (acc |=> ack_o ##1 !ack_o)
        else $error("ack not single cycle");

endmodule : wed_wake_event_detect
`default_nettype wire

// *** dv/wed_rx_model.sv ***
/*
  receive path model: sends one frame byte per clock from frame[].
  assumes the bench fills frame[] and calls sendFrame.
*/
`timescale 1ns/10ps
`default_nettype none
module wed_rx_model (
    input  wire logic             clock,
    output var  wed_pkg::wed_rx_t rxByte
);
    logic [7:0] frame [0:127];
    initial rxByte = '0;
    task automatic sendFrame(input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge clock);
            rxByte <= {1'b1, i == 0, i == len - 1, frame[i]};
        end
        @(posedge clock);
        // data is not held once the frame ends
        rxByte <= {3'b000, ~frame[len - 1]};
    endtask : sendFrame
endmodule : wed_rx_model
`default_nettype wire

// *** dv/tb_wake_event_detect.sv ***
/*
  self-checking bench of the wake event detector over wishbone.
  assumes wed_pkg and wed_rx_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_wake_event_detect;
    logic             clock, resetn, we, stb, cyc, linkStatus, cfgLoad, pg;
    logic             ack_o, remoteWakeOut, eventOut, busMasterBlock, txBlock, rxFlush;
    logic [7:0]       adr;
    logic [31:0]      wdat, rd, dat_o;
    wed_pkg::wed_rx_t rxByte;
    int               fail_count, total_checks, cycles, k;
    logic [47:0]      sta = 48'h0a9b8c7d6e5f;

    wed_wake_event_detect uut (.clock(clock), .resetn(resetn), .adr_i(adr),
        .dat_i(wdat), .we_i(we), .sel_i(4'hf), .stb_i(stb), .cyc_i(cyc),
        .ack_o(ack_o), .dat_o(dat_o), .rxByte(rxByte), .linkStatus(linkStatus),
        .powerGoodIn(pg), .cfgLoad(cfgLoad), .cfgLinkChangeMode(1'b1),
        .remoteWakeOut(remoteWakeOut), .eventOut(eventOut),
        .busMasterBlock(busMasterBlock), .txBlock(txBlock), .rxFlush(rxFlush));
    wed_rx_model rx (.clock(clock), .rxByte(rxByte));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("mismatch at %0t: timeout", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clock); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wbAcc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbAcc(1'b1, a, d);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] msk, exp, input string m);
        wbAcc(1'b0, a, 32'h0);
        chk(rd & msk, exp, m);
    endtask : rdChk

    task automatic ramWr(input logic [6:0] a, input logic [39:0] w);
        wr(wed_pkg::OFS_INDEX, {16'h0, w[7:0], 1'b0, a});
        wr(wed_pkg::OFS_LOWDATA, {16'h0, w[23:8]});
        wr(wed_pkg::OFS_HIGHDATA, {16'h0, w[39:24]});
    endtask : ramWr

    initial begin
        {resetn, we, stb, cyc, linkStatus, cfgLoad, adr, wdat} = '0;
        pg = 1'b1;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        // ----------------------------------------
        // pattern ram access
        // ----------------------------------------
        ramWr(7'h05, 40'hcdab34128a);
        wr(wed_pkg::OFS_INDEX, 32'h0005);
        rdChk(wed_pkg::OFS_HIGHDATA, 32'hffff, 32'hcdab, "high");
        rdChk(wed_pkg::OFS_INDEX, 32'hff00, 32'h8a00, "byte0");
        wr(wed_pkg::OFS_INDEX, 32'h0080);
        rdChk(wed_pkg::OFS_INDEX, 32'h80, 32'h80, "mode");
        wr(wed_pkg::OFS_LOWDATA, 32'h0);
        wr(wed_pkg::OFS_HIGHDATA, 32'h0);
        @(posedge clock);
        resetn <= 1'b0;
        @(posedge clock);
        resetn <= 1'b1;
        wr(wed_pkg::OFS_INDEX, 32'h0005);
        rdChk(wed_pkg::OFS_LOWDATA, 32'hffff, 32'h3412, "kept");
        wr(8'h40, 32'hffff);
        rdChk(8'h40, 32'hffffffff, 32'h0, "unmapped");
        $display("test ram done");
        // ----------------------------------------
        // link change
        // ----------------------------------------
        @(posedge clock);
        cfgLoad <= 1'b1;
        @(posedge clock);
        cfgLoad <= 1'b0;
        rdChk(wed_pkg::OFS_WAKECTL, 32'h100, 32'h100, "link_change_mode");
        wr(wed_pkg::OFS_WAKECTL, 32'h500);
        linkStatus <= 1'b1;
        repeat (6) @(posedge clock);
        chk({remoteWakeOut, eventOut}, 32'h3, "link out");
        rdChk(wed_pkg::OFS_WAKECTL, 32'h200, 32'h200, "lcflag");
        rdChk(wed_pkg::OFS_PMCTL, 32'h8000, 32'h8000, "status");
        wr(wed_pkg::OFS_WAKECTL, 32'h200);
        wr(wed_pkg::OFS_PMCTL, 32'h8100);
        repeat (4) @(posedge clock);
        chk({remoteWakeOut, eventOut}, 32'h0, "cleared");
        $display("test link done");
        // ----------------------------------------
        // pattern match
        // ----------------------------------------
        ramWr(7'h00, 40'h0000000201);
        ramWr(7'h01, 40'h0);
        ramWr(7'h02, 40'hee06050497);
        for (int i = 0; i < 20; i++) rx.frame[i] = i[7:0];
        wr(wed_pkg::OFS_INDEX, 32'h0080);
        for (k = 0; k < 2; k++) begin
            rx.sendFrame(20);
            repeat (3) @(posedge clock);
            rdChk(wed_pkg::OFS_WAKECTL, 32'h80, {24'h0, k == 0, 7'h0}, "pattern_matched_flag");
            chk(eventOut, 32'(k == 0), "pm event");
            wr(wed_pkg::OFS_WAKECTL, 32'h80);
            wr(wed_pkg::OFS_PMCTL, 32'h8100);
            rx.frame[5] = 8'h55;
        end
        $display("test pattern done");
        // ----------------------------------------
        // wake frame
        // ----------------------------------------
        wr(wed_pkg::OFS_STALO, sta[31:0]);
        wr(wed_pkg::OFS_STAHI, {16'h0, sta[47:32]});
        wr(wed_pkg::OFS_EXTCTL, 32'h2);
        wr(wed_pkg::OFS_EXTCTL, 32'h3);
        wr(wed_pkg::OFS_EXTCTL, 32'h7);
        @(posedge clock);
        chk({busMasterBlock, txBlock, rxFlush}, 32'h7, "blocks");
        for (k = 0; k < 5; k++) begin
            wr(wed_pkg::OFS_EXTCTL, k == 3 ? 32'h27 : 32'h7);
            wr(wed_pkg::OFS_WAKECTL, k == 4 ? 32'h60 : 32'h20);
            for (int i = 0; i < 110; i++)
                rx.frame[i] = i < 6 ? (k < 2 ? sta[8*i+:8] : 8'hff) :
                              i < 14 ? 8'h00 : sta[8*((i-14)%6)+:8];
            if (k == 1) rx.frame[60][0] = ~rx.frame[60][0];
            rx.sendFrame(110);
            repeat (3) @(posedge clock);
            rdChk(wed_pkg::OFS_WAKECTL, 32'h20, {26'h0, k != 1 && k != 2, 5'h0}, "wake");
            chk(remoteWakeOut, 32'(k != 1 && k != 2), "wake pin");
        end
        wr(wed_pkg::OFS_EXTCTL, 32'h3);
        repeat (2) @(posedge clock);
        chk({busMasterBlock, txBlock, rxFlush}, 32'h0, "no enable");
        pg <= 1'b0;
        repeat (3) @(posedge clock);
        chk({busMasterBlock, txBlock, rxFlush}, 32'h7, "power down");
        $display("test wake done");
        complete_run();
    end
endmodule : tb_wake_event_detect
`default_nettype wire
